// *** hw/bxe_core.sv ***
// execute stage for a subset of an 8-bit core's byte operations
// assumes one instruction per cycle offered on INSTR_I with VALID_I; the file
// register value is read by the core beforehand and written back from FILE_WR_*
//
// What this block does
// - return pops stack into pc, two cycles
// - rotate right through carry, carry only
// - select bit picks accumulator or file destination
// - sleep clears powerdown, sets timeout flag
// - sleep zeroes watchdog counter and prescaler
// - after sleep, halt; no further instructions until WAKE_I
// - literal minus accumulator into accumulator
// - subtractions update carry, digit carry, zero
// - file minus accumulator, routed by select
// - swap nibbles, flags untouched
// - xor literal into accumulator, zero only
// - xor file, routed by select, zero only
`timescale 1ns/1ps
module bxe_core
    import bxe_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    input wire logic VALID_I,
    input wire bxe_instr_t INSTR_I,
    input wire logic [12:0] STACK_TOP_ENTRY_I,
    input wire logic WAKE_I,
    input wire logic WDT_TICK_I,
    output logic READY_O,
    output logic [7:0] W_O,
    output logic [4:0] FLAGS_O,
    output logic FILE_WR_O,
    output logic [7:0] FILE_WR_DATA_O,
    output logic STACK_POP_O,
    output logic PC_LOAD_O,
    output logic [12:0] PC_O,
    output logic SLEEPING_O,
    output logic [7:0] WATCHDOG_COUNTER_O,
    output logic [7:0] WDT_PRESCALE_O
);

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        bxe_state_t st;
        logic [7:0] w;
        logic [4:0] flags;
        logic file_wr;
        logic [7:0] file_data;
        logic pop;
        logic pc_load;
        logic [12:0] pc;
        logic [7:0] wdt;
        logic [7:0] pre;
        logic ready;
        logic sleeping;
    } bxe_core_state_t;

    bxe_core_state_t s_q;
    bxe_core_state_t s_d;
    bxe_alu_res_t alu;
    logic take;

    bxe_alu bxe_alu_i (
        .op_i(INSTR_I.op),
        .w_i(s_q.w),
        .lit_i(INSTR_I.literal),
        .file_i(INSTR_I.file_val),
        .carry_i(s_q.flags[BXE_FLAG_C]),
        .res_o(alu)
    );

    ////////////////////////////////////////////////////////////////////////
    // no new instruction while finishing a return or asleep
    assign take = VALID_I && (s_q.st == BXE_ST_RUN);

    always_comb begin
        s_d = s_q;
        s_d.file_wr = 1'b0;
        s_d.pop = 1'b0;
        s_d.pc_load = 1'b0;
        // watchdog runs outside sleep clears; counter wraps
        if (WDT_TICK_I) begin
            {s_d.wdt, s_d.pre} = 16'({s_q.wdt, s_q.pre} + 16'h0001);
        end
        unique case (s_q.st)
            BXE_ST_RUN: begin
                if (take) begin
                    unique case (INSTR_I.op)
                        BXE_OP_RETURN: begin
                            s_d.pop = 1'b1;
                            s_d.pc = STACK_TOP_ENTRY_I;
                            s_d.pc_load = 1'b1;
                            s_d.st = BXE_ST_RET2;
                        end
                        BXE_OP_SLEEP: begin
                            s_d.flags[BXE_FLAG_PD] = 1'b0;
                            s_d.flags[BXE_FLAG_TO] = 1'b1;
                            s_d.wdt = BXE_WDT_CLR;
                            s_d.pre = BXE_PRE_CLR;
                            s_d.st = BXE_ST_SLEEP;
                        end
                        BXE_OP_SUB_LIT, BXE_OP_XOR_LIT: begin
                            s_d.w = alu.value;
                            s_d.flags[BXE_FLAG_Z] = alu.z;
                            if (INSTR_I.op == BXE_OP_SUB_LIT) begin
                                s_d.flags[BXE_FLAG_C] = alu.c;
                                s_d.flags[BXE_FLAG_DC] = alu.dc;
                            end
                        end
                        BXE_OP_SUB_FILE, BXE_OP_XOR_FILE, BXE_OP_SWAP,
                        BXE_OP_ROT_LEFT, BXE_OP_ROT_RIGHT: begin
                            if (INSTR_I.dest_file) begin
                                s_d.file_wr = 1'b1;
                                s_d.file_data = alu.value;
                            end else begin
                                s_d.w = alu.value;
                            end
                            if (INSTR_I.op == BXE_OP_SUB_FILE) begin
                                s_d.flags[BXE_FLAG_C] = alu.c;
                                s_d.flags[BXE_FLAG_DC] = alu.dc;
                                s_d.flags[BXE_FLAG_Z] = alu.z;
                            end
                            if (INSTR_I.op == BXE_OP_XOR_FILE) begin
                                s_d.flags[BXE_FLAG_Z] = alu.z;
                            end
                            if (INSTR_I.op == BXE_OP_ROT_LEFT ||
                                INSTR_I.op == BXE_OP_ROT_RIGHT) begin
                                s_d.flags[BXE_FLAG_C] = alu.c;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            // second cycle of a return: a bubble, flags untouched
            BXE_ST_RET2: s_d.st = BXE_ST_RUN;
            BXE_ST_SLEEP: begin
                // oscillator halted, so the watchdog only advances by WDT_TICK_I
                if (WAKE_I) begin
                    s_d.st = BXE_ST_RUN;
                end
            end
            default: s_d.st = BXE_ST_RUN;
        endcase
        // status decoded ahead of the flop so the ports carry no decode logic
        s_d.ready = (s_d.st == BXE_ST_RUN);
        s_d.sleeping = (s_d.st == BXE_ST_SLEEP);
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            s_q <= '{st: BXE_ST_RUN, w: BXE_W_RST, flags: BXE_FLAGS_RST,
                     file_wr: 1'b0, file_data: BXE_ZERO, pop: 1'b0,
                     pc_load: 1'b0, pc: BXE_PC_RST, wdt: BXE_WDT_CLR,
                     pre: BXE_PRE_CLR, ready: 1'b1, sleeping: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign READY_O = s_q.ready;
    assign W_O = s_q.w;
    assign FLAGS_O = s_q.flags;
    assign FILE_WR_O = s_q.file_wr;
    assign FILE_WR_DATA_O = s_q.file_data;
    assign STACK_POP_O = s_q.pop;
    assign PC_LOAD_O = s_q.pc_load;
    assign PC_O = s_q.pc;
    assign SLEEPING_O = s_q.sleeping;
    assign WATCHDOG_COUNTER_O = s_q.wdt;
    assign WDT_PRESCALE_O = s_q.pre;

    ////////////////////////////////////////////////////////////////////////
    a_return_two_cycle: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        take && INSTR_I.op == BXE_OP_RETURN |=> STACK_POP_O && PC_O == $past(STACK_TOP_ENTRY_I)
        && !READY_O && $stable(FLAGS_O) ##1 READY_O)
        else $error("return did not pop and stall one cycle");
    a_rot_right: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        take && INSTR_I.op == BXE_OP_ROT_RIGHT && !INSTR_I.dest_file |=>
        W_O == {$past(FLAGS_O[BXE_FLAG_C]), $past(INSTR_I.file_val[7:1])}
        && FLAGS_O[BXE_FLAG_C] == $past(INSTR_I.file_val[0]))
        else $error("rotate right result wrong");
    a_dest_file: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        take && INSTR_I.op == BXE_OP_SWAP && INSTR_I.dest_file |=>
        FILE_WR_O && $stable(W_O)) else $error("file destination not honoured");
    a_sleep_flags: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        take && INSTR_I.op == BXE_OP_SLEEP |=> !FLAGS_O[BXE_FLAG_PD] && FLAGS_O[BXE_FLAG_TO]
        && FLAGS_O[2:0] == $past(FLAGS_O[2:0])) else $error("sleep flags wrong");
    a_sleep_wdt: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        take && INSTR_I.op == BXE_OP_SLEEP |=> WATCHDOG_COUNTER_O == BXE_WDT_CLR
        && WDT_PRESCALE_O == BXE_PRE_CLR) else $error("watchdog not cleared by sleep");
    a_sleep_halt: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        SLEEPING_O && !WAKE_I |=> SLEEPING_O && !FILE_WR_O && $stable(W_O))
        else $error("instruction executed while asleep");
    a_sub_lit: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        take && INSTR_I.op == BXE_OP_SUB_LIT |=>
        W_O == 8'($past(INSTR_I.literal) - $past(W_O)))
        else $error("literal subtract wrong");
    a_sub_carry: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        take && INSTR_I.op == BXE_OP_SUB_FILE |=>
        FLAGS_O[BXE_FLAG_C] == ($past(INSTR_I.file_val) >= $past(W_O))
        && $stable(FLAGS_O[4:3])) else $error("subtract carry wrong");
    a_xor_lit: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        take && INSTR_I.op == BXE_OP_XOR_LIT |=> W_O == ($past(W_O) ^ $past(INSTR_I.literal))
        && FLAGS_O[BXE_FLAG_Z] == (W_O == BXE_ZERO) && $stable(FLAGS_O[1:0]))
        else $error("xor literal wrong");
    a_sub_file_dest: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        take && INSTR_I.op == BXE_OP_SUB_FILE && INSTR_I.dest_file |=> FILE_WR_O
        && FILE_WR_DATA_O == 8'($past(INSTR_I.file_val) - $past(W_O))
        && $stable(W_O))
        else $error("file subtract result misrouted");
    a_swap_nibbles: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        take && INSTR_I.op == BXE_OP_SWAP && !INSTR_I.dest_file |=>
        W_O == {$past(INSTR_I.file_val[3:0]), $past(INSTR_I.file_val[7:4])}
        && $stable(FLAGS_O))
        else $error("nibble swap wrong");
    a_xor_file_flags: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        take && INSTR_I.op == BXE_OP_XOR_FILE |=>
        $stable(FLAGS_O[1:0]) && $stable(FLAGS_O[4:3])
        && FLAGS_O[BXE_FLAG_Z] == ($past(W_O) == $past(INSTR_I.file_val)))
        else $error("xor file flags wrong");
    a_rot_left: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        take && INSTR_I.op == BXE_OP_ROT_LEFT && !INSTR_I.dest_file |=>
        W_O == {$past(INSTR_I.file_val[6:0]), $past(FLAGS_O[BXE_FLAG_C])}
        && FLAGS_O[BXE_FLAG_C] == $past(INSTR_I.file_val[7])
        && $stable(FLAGS_O[4:1]))
        else $error("rotate left result wrong");

endmodule : bxe_core

// *** hw/bxe_pkg.sv ***
// package for the byte-op execute subset: op codes, flag layout, reset values
// assumes the surrounding core decodes instructions into bxe_op_t
package bxe_pkg;

    typedef enum logic [3:0] {
        BXE_OP_NONE = 4'h0,
        BXE_OP_ROT_LEFT = 4'h1,
        BXE_OP_ROT_RIGHT = 4'h2,
        BXE_OP_RETURN = 4'h3,
        BXE_OP_SLEEP = 4'h4,
        BXE_OP_SUB_LIT = 4'h5,
        BXE_OP_SUB_FILE = 4'h6,
        BXE_OP_SWAP = 4'h7,
        BXE_OP_XOR_LIT = 4'h8,
        BXE_OP_XOR_FILE = 4'h9
    } bxe_op_t;

    typedef enum logic [1:0] {
        BXE_ST_RUN = 2'b00,
        BXE_ST_RET2 = 2'b01,
        BXE_ST_SLEEP = 2'b10
    } bxe_state_t;

    localparam int BXE_DATA_W = 8;
    localparam int BXE_PC_W = 13;
    localparam int BXE_WDT_W = 8;
    localparam int BXE_PRE_W = 8;

    // flag positions inside the status vector
    localparam int BXE_FLAG_C = 0;
    localparam int BXE_FLAG_DC = 1;
    localparam int BXE_FLAG_Z = 2;
    localparam int BXE_FLAG_PD = 3;
    localparam int BXE_FLAG_TO = 4;
    localparam logic [4:0] BXE_FLAGS_RST = 5'h18;

    localparam logic [7:0] BXE_W_RST = 8'h00;
    localparam logic [12:0] BXE_PC_RST = 13'h0000;
    localparam logic [7:0] BXE_WDT_CLR = 8'h00;
    localparam logic [7:0] BXE_PRE_CLR = 8'h00;
    localparam logic [7:0] BXE_ZERO = 8'h00;

    typedef struct packed {
        bxe_op_t op;
        logic dest_file;
        logic [7:0] literal;
        logic [7:0] file_val;
    } bxe_instr_t;

    typedef struct packed {
        logic [7:0] value;
        logic c;
        logic dc;
        logic z;
    } bxe_alu_res_t;

endpackage : bxe_pkg

// *** hw/bxe_alu.sv ***
// combinational byte alu for subtract, xor, swap and rotates
// assumes operands are stable for the cycle; flags are raw, caller masks them
`timescale 1ns/1ps
module bxe_alu
    import bxe_pkg::*;
(
    input wire bxe_op_t op_i,
    input wire logic [7:0] w_i,
    input wire logic [7:0] lit_i,
    input wire logic [7:0] file_i,
    input wire logic carry_i,
    output bxe_alu_res_t res_o
);
    logic [8:0] diff;
    logic [4:0] ndiff;
    logic [7:0] minuend;

    always_comb begin
        minuend = (op_i == BXE_OP_SUB_LIT) ? lit_i : file_i;
        // carry set means no borrow, so add the complement plus one
        diff = {1'b0, minuend} + {1'b0, ~w_i} + 9'h001;
        ndiff = {1'b0, minuend[3:0]} + {1'b0, ~w_i[3:0]} + 5'h01;
        res_o = '0;
        res_o.c = carry_i;
        unique case (op_i)
            BXE_OP_SUB_LIT, BXE_OP_SUB_FILE: begin
                res_o.value = diff[7:0];
                res_o.c = diff[8];
                res_o.dc = ndiff[4];
            end
            BXE_OP_XOR_LIT: res_o.value = w_i ^ lit_i;
            BXE_OP_XOR_FILE: res_o.value = w_i ^ file_i;
            BXE_OP_SWAP: res_o.value = {file_i[3:0], file_i[7:4]};
            BXE_OP_ROT_RIGHT: begin
                res_o.value = {carry_i, file_i[7:1]};
                res_o.c = file_i[0];
            end
            BXE_OP_ROT_LEFT: begin
                res_o.value = {file_i[6:0], carry_i};
                res_o.c = file_i[7];
            end
            default: res_o.value = BXE_ZERO;
        endcase
        res_o.z = (res_o.value == BXE_ZERO);
    end
endmodule : bxe_alu

// *** tb/bxe_core_tb.sv ***
// self-checking bench for the byte-op execute subset
// assumes bxe_pkg and bxe_core compiled first; bench drives all ports itself
`timescale 1ns/1ps
module bxe_core_tb;
    import bxe_pkg::*;

    logic clk_sys;
    logic rst;
    logic valid;
    logic wake;
    logic tick;
    logic tick_en;
    bxe_instr_t instr;
    logic [12:0] stack_top;
    logic ready, file_wr, pop, pc_load, sleeping;
    logic [7:0] w, file_wr_data, wdt, pre;
    logic [4:0] flags;
    logic [12:0] pc;
    logic [15:0] cnt_exp;
    logic [7:0] w_exp;
    logic [4:0] fl_exp;
    int n_fail;
    int comparisons;
    int cyc;
    bxe_op_t alu_ops [7] = '{BXE_OP_ROT_LEFT, BXE_OP_ROT_RIGHT, BXE_OP_SUB_LIT,
        BXE_OP_SUB_FILE, BXE_OP_SWAP, BXE_OP_XOR_LIT, BXE_OP_XOR_FILE};

    bxe_core bxe_core_i (
        .CLK_SYS_I(clk_sys), .RST_I(rst), .VALID_I(valid), .INSTR_I(instr),
        .STACK_TOP_ENTRY_I(stack_top), .WAKE_I(wake), .WDT_TICK_I(tick),
        .READY_O(ready), .W_O(w), .FLAGS_O(flags), .FILE_WR_O(file_wr),
        .FILE_WR_DATA_O(file_wr_data), .STACK_POP_O(pop), .PC_LOAD_O(pc_load),
        .PC_O(pc), .SLEEPING_O(sleeping), .WATCHDOG_COUNTER_O(wdt), .WDT_PRESCALE_O(pre)
    );

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // tick timing is random so the counter model sees uneven spacing
    always @(posedge clk_sys) begin
        tick <= tick_en & 1'($urandom_range(1, 0));
        if (rst) cnt_exp <= 16'h0000;
        else if (valid && ready && instr.op == BXE_OP_SLEEP) cnt_exp <= 16'h0000;
        else if (tick) cnt_exp <= cnt_exp + 16'h0001;
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic close_out();
        $display("mismatches=%0d comparisons=%0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : close_out

    // one alu op, then expected accumulator, flags and write-back
    task automatic issue(input bxe_op_t op, input logic d, input logic [7:0] lit,
        input logic [7:0] fv);
        logic [7:0] a;
        logic [7:0] r;
        logic c;
        logic wr;
        @(posedge clk_sys);
        valid <= 1'b1;
        instr <= '{op: op, dest_file: d, literal: lit, file_val: fv};
        @(posedge clk_sys);
        valid <= 1'b0;
        #1;
        a = (op == BXE_OP_SUB_LIT || op == BXE_OP_XOR_LIT) ? lit : fv;
        r = a;
        c = fl_exp[BXE_FLAG_C];
        case (op)
            BXE_OP_ROT_LEFT: {c, r} = {fv, fl_exp[BXE_FLAG_C]};
            BXE_OP_ROT_RIGHT: {r, c} = {fl_exp[BXE_FLAG_C], fv};
            BXE_OP_SUB_LIT, BXE_OP_SUB_FILE: begin
                r = a - w_exp;
                c = a >= w_exp;
                fl_exp[BXE_FLAG_DC] = a[3:0] >= w_exp[3:0];
                fl_exp[BXE_FLAG_Z] = r == 8'h00;
            end
            BXE_OP_SWAP: r = {fv[3:0], fv[7:4]};
            default: begin
                r = a ^ w_exp;
                fl_exp[BXE_FLAG_Z] = r == 8'h00;
            end
        endcase
        fl_exp[BXE_FLAG_C] = c;
        wr = d && op != BXE_OP_SUB_LIT && op != BXE_OP_XOR_LIT;
        if (!wr) w_exp = r;
        chk(w, w_exp);
        chk(flags, fl_exp);
        chk(file_wr, wr);
        if (wr) chk(file_wr_data, r);
        chk({wdt, pre}, cnt_exp);
    endtask : issue

    // return, with an op offered in the bubble that must be refused
    task automatic do_return();
        @(posedge clk_sys);
        valid <= 1'b1;
        instr <= '{op: BXE_OP_RETURN, dest_file: 1'b0, literal: 8'h00, file_val: 8'h00};
        stack_top <= 13'($urandom);
        @(posedge clk_sys);
        instr <= '{op: BXE_OP_XOR_LIT, dest_file: 1'b0, literal: 8'hff, file_val: 8'h00};
        #1;
        chk({pop, pc_load, ready}, 3'b110);
        chk(pc, stack_top);
        chk(flags, fl_exp);
        @(posedge clk_sys);
        valid <= 1'b0;
        #1;
        chk({pop, pc_load, ready}, 3'b001);
        chk(w, w_exp);
    endtask : do_return

    // sleep, offers refused while asleep, then wake
    task automatic do_sleep();
        @(posedge clk_sys);
        valid <= 1'b1;
        tick_en <= 1'b0;
        instr <= '{op: BXE_OP_SLEEP, dest_file: 1'b0, literal: 8'h00, file_val: 8'h00};
        @(posedge clk_sys);
        instr <= '{op: BXE_OP_XOR_LIT, dest_file: 1'b0, literal: 8'h5a, file_val: 8'h00};
        #1;
        fl_exp[BXE_FLAG_PD] = 1'b0;
        fl_exp[BXE_FLAG_TO] = 1'b1;
        chk(flags, fl_exp);
        chk({wdt, pre}, 16'h0000);
        chk({sleeping, ready}, 2'b10);
        repeat (5) @(posedge clk_sys);
        #1;
        chk(w, w_exp);
        chk({sleeping, ready}, 2'b10);
        @(posedge clk_sys);
        valid <= 1'b0;
        wake <= 1'b1;
        @(posedge clk_sys);
        wake <= 1'b0;
        tick_en <= 1'b1;
        #1;
        chk({sleeping, ready}, 2'b01);
    endtask : do_sleep

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h0671));
        rst = 1'b1;
        valid = 1'b0;
        wake = 1'b0;
        tick = 1'b0;
        tick_en = 1'b0;
        instr = '0;
        stack_top = 13'h0000;
        n_fail = 0;
        comparisons = 0;
        cyc = 0;
        w_exp = BXE_W_RST;
        fl_exp = BXE_FLAGS_RST;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        chk({ready, w, flags}, {1'b1, BXE_W_RST, BXE_FLAGS_RST});
        tick_en <= 1'b1;
        // borrow, nibble borrow and zero boundaries
        issue(BXE_OP_XOR_LIT, 1'b0, 8'h01, 8'h00);
        issue(BXE_OP_SUB_LIT, 1'b0, 8'h00, 8'h00);
        issue(BXE_OP_SUB_FILE, 1'b1, 8'h00, 8'hff);
        issue(BXE_OP_SUB_FILE, 1'b0, 8'h10, 8'h0f);
        issue(BXE_OP_XOR_FILE, 1'b1, 8'h00, w_exp);
        issue(BXE_OP_ROT_RIGHT, 1'b0, 8'h00, 8'h01);
        issue(BXE_OP_ROT_LEFT, 1'b0, 8'h00, 8'he6);
        issue(BXE_OP_ROT_LEFT, 1'b1, 8'h00, 8'h80);
        issue(BXE_OP_SWAP, 1'b1, 8'h00, 8'ha5);
        do_return();
        for (int i = 0; i < 300; i++) begin
            issue(alu_ops[$urandom_range(6, 0)], 1'($urandom), 8'($urandom), 8'($urandom));
            if (i % 50 == 25) do_return();
            if (i % 100 == 60) do_sleep();
        end
        close_out();
    end

endmodule : bxe_core_tb
